//--- asr_port.sv
// asr_port: apb-controlled serial result port with result fifo.
// assumes results arrive in straight binary on the pclk domain; the
// link pins (sclk, chip select, read, shared data pins) are asynchronous.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps

// =========================================================
// result fifo
module asr_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   wire              push = in_valid && in_ready && ce;
   wire              pop  = out_valid && out_ready && ce;

   // flags follow the count, so full and empty are exact
   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem[rd_reg];
   assign level     = cnt_reg;

   // storage has no reset, pointers do
   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop)  rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // asr_fifo

// =========================================================
// top: apb slave, conversion tracking, serial frame engine
module asr_port (
   // clock, reset, enable
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      ce,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   // result stream from the converter core
   input  wire logic                      res_valid,
   input  wire logic [asr_pkg::RES_W-1:0] res_data,
   output logic                           res_ready,
   // conversion in progress
   output logic                           busy,
   // shared data pins, enables low while driving
   input  wire logic                      parallel_bit_seven_in,
   output logic                           parallel_bit_seven_out,
   output logic                           parallel_bit_seven_oe_n,
   input  wire logic                      parallel_bit_eight_in,
   output logic                           parallel_bit_eight_out,
   output logic                           parallel_bit_eight_oe_n,
   input  wire logic                      parallel_bit_nine_in,
   output logic                           parallel_bit_nine_out,
   output logic                           parallel_bit_nine_oe_n,
   output logic                           parallel_bit_ten,
   // serial link
   input  wire logic                      sclk_in,
   output logic                           sclk_out,
   output logic                           sclk_oe_n,
   input  wire logic                      cs_n,
   input  wire logic                      rd_n,
   output logic                           frame_sync
);
   import asr_pkg::*;

   // =========================================================
   // registers
   logic [3:0]         ctrl_reg;
   logic [15:0]        div_reg;
   logic [RES_W-1:0]   result_reg;
   logic               busy_reg;
   logic [31:0]        prdata_reg;
   logic               pslverr_reg;
   asr_state_t         state_reg;
   logic [RES_W-1:0]   shift_reg;
   logic [CNT_W-1:0]   bit_reg;
   logic [1:0]         qph_reg;
   logic [7:0]         qcnt_reg;
   logic               new_reg;     // latched result not yet sent
   logic               sclk_reg;
   logic               sync_reg;
   logic [3:0]         pin_out_reg;  // bits seven..ten or serial out
   logic               pin_oe_n_reg;
   logic               sclk_oe_n_reg;
   logic               start_m;
   logic [2:0]         sclk_s;      // [0] sync stage 1 only
   logic [1:0]         cs_s;
   logic [1:0]         rd_s;
   logic [1:0]         psel_s;      // strobe polarity pin
   logic [1:0]         inv_s;       // clock invert pin
   logic [1:0]         rdc_s;       // read during convert / chain pin

   // =========================================================
   // pin synchronisers, stage one feeds stage two only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s <= '0;
         cs_s   <= 2'h3;
         rd_s   <= 2'h3;
         psel_s <= '0;
         inv_s  <= '0;
         rdc_s  <= '0;
      end else if (ce) begin
         sclk_s <= {sclk_s[1:0], sclk_in};
         cs_s   <= {cs_s[0], cs_n};
         rd_s   <= {rd_s[0], rd_n};
         psel_s <= {psel_s[0], parallel_bit_seven_in};
         inv_s  <= {inv_s[0], parallel_bit_eight_in};
         rdc_s  <= {rdc_s[0], parallel_bit_nine_in};
      end
   end

   // =========================================================
   // mode decode
   wire        serial_mode = (ctrl_reg[CTRL_MODE_LO +: 2] == MODE_SERIAL);
   wire        slave_mode  = serial_mode && ctrl_reg[CTRL_CSRC];
   wire        master_mode = serial_mode && !ctrl_reg[CTRL_CSRC];
   wire        sync_pol    = psel_s[1];
   wire        clk_inv     = inv_s[1];
   wire        rdc_sel     = rdc_s[1];
   wire        chain_in    = rdc_s[1];  // same pin in slave mode
   wire        sclk_rise   = sclk_s[1] && !sclk_s[2];
   wire        sclk_fall   = !sclk_s[1] && sclk_s[2];
   wire        upd_edge    = clk_inv ? sclk_fall : sclk_rise;
   wire        rd_active   = !cs_s[1] && !rd_s[1];

   // =========================================================
   // apb decode
   wire        apb_acc   = psel && penable && ce;
   wire        apb_wr    = apb_acc && pwrite;
   wire        hit_ctrl  = (paddr == OFF_CTRL);
   wire        hit_div   = (paddr == OFF_DIV);
   wire        hit_conv  = (paddr == OFF_CONV);
   wire        hit_stat  = (paddr == OFF_STATUS);
   wire        hit_res   = (paddr == OFF_RESULT);
   wire        hit_any   = hit_ctrl | hit_div | hit_conv | hit_stat | hit_res;
   wire        conv_go   = apb_wr && hit_conv && pwdata[CONV_START];

   // =========================================================
   // fifo in the result path; it drains only into a latch
   logic                   f_valid;
   logic [RES_W-1:0]       f_data;
   logic [$clog2(FIFO_D):0] f_level;
   wire                    latch_go = busy_reg && f_valid;

   asr_fifo #(
      .WIDTH (RES_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .in_valid  (res_valid),
      .in_ready  (res_ready),
      .in_data   (res_data),
      .out_valid (f_valid),
      .out_ready (busy_reg),
      .out_data  (f_data),
      .level     (f_level)
   );

   // output coding: msb flip gives two's complement
   wire [RES_W-1:0] coded = ctrl_reg[CTRL_CODE] ? result_reg :
      {~result_reg[RES_W-1], result_reg[RES_W-2:0]};

   // read data mux
   wire [31:0] stat_word = {19'h0, 5'(f_level), 6'h0,
                            (state_reg != ST_IDLE), busy_reg};
   wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_reg} :
                        hit_div  ? {16'h0, div_reg}  :
                        hit_stat ? stat_word         :
                        hit_res  ? {14'h0, result_reg} : 32'h0;

   // =========================================================
   // apb registers; zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg    <= CTRL_RESET;
         div_reg     <= DIV_RESET;
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (ce) begin
         if (apb_wr && hit_ctrl) ctrl_reg <= pwdata[3:0];
         if (apb_wr && hit_div)  div_reg  <= pwdata[15:0];
         if (psel && !penable) prdata_reg <= rd_mux;
         if (psel && !penable) pslverr_reg <= !hit_any;
      end
   end

   // =========================================================
   // conversion tracking: busy until the result is latched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg   <= 1'b0;
         result_reg <= '0;
         new_reg    <= 1'b0;
      end else if (ce) begin
         if (latch_go) begin
            busy_reg   <= 1'b0;
            result_reg <= f_data;
            new_reg    <= 1'b1;
         end else if (conv_go) begin
            busy_reg <= 1'b1;
         end
         // a master frame start consumes the pending result; a latch wins
         if (!latch_go && start_m) new_reg <= 1'b0;
      end
   end

   // =========================================================
   // frame start conditions; host keeps the selects steady per frame
   wire [7:0] q_len   = rdc_sel ? ((div_reg[DIV_RDC_LO +: 8] < RDC_MIN_Q) ?
                        RDC_MIN_Q : div_reg[DIV_RDC_LO +: 8]) :
                        ((div_reg[7:0] == 8'h0) ? 8'h1 : div_reg[7:0]);
   wire start_rdc = rdc_sel && conv_go && !busy_reg;
   wire start_rac = !rdc_sel && new_reg && !busy_reg;
   assign start_m = (state_reg == ST_IDLE) && master_mode &&
                    (start_rdc || start_rac);
   wire start_s   = (state_reg == ST_IDLE) && slave_mode && rd_active;
   wire q_done    = (qcnt_reg == q_len - 8'h1);
   wire last_bit  = (bit_reg == CNT_W'(RES_W - 1));

   // =========================================================
   // frame engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         shift_reg <= '0;
         bit_reg   <= '0;
         qph_reg   <= '0;
         qcnt_reg  <= '0;
      end else if (ce) begin
         case (state_reg)
            ST_IDLE: begin
               qph_reg  <= '0;
               qcnt_reg <= '0;
               bit_reg  <= '0;
               if (start_m || start_s) begin
                  shift_reg <= coded;
                  state_reg <= start_m ? ST_MASTER : ST_SLAVE;
               end
            end
            // four quarters per bit: data moves only at the bit boundary
            ST_MASTER: begin
               qcnt_reg <= q_done ? 8'h0 : qcnt_reg + 8'h1;
               if (q_done) begin
                  qph_reg <= qph_reg + 2'h1;
                  if (qph_reg == 2'h3) begin
                     shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
                     bit_reg   <= bit_reg + 1'b1;
                     if (last_bit) state_reg <= ST_IDLE;
                  end
               end
            end
            // slave: shift on the update edge, chain bit enters the lsb
            ST_SLAVE: begin
               if (!rd_active) begin
                  state_reg <= ST_IDLE;
               end else if (upd_edge) begin
                  shift_reg <= {shift_reg[RES_W-2:0], chain_in};
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // registered pin drivers
   wire in_master = (state_reg == ST_MASTER);
   // clock pulses in quarters 1..2, so the pulse is centred mid-bit, each edge a quarter bit from the data change
   wire sclk_lvl  = in_master && (qph_reg == 2'h1 || qph_reg == 2'h2);
   wire [3:0] par_bits = result_reg[10:7];
   wire ser_bit   = (state_reg == ST_IDLE) ? 1'b0 : shift_reg[RES_W-1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_reg     <= 1'b0;
         sclk_oe_n_reg <= 1'b0;
         sync_reg     <= 1'b0;
         pin_out_reg  <= '0;
         pin_oe_n_reg <= 1'b1;
      end else if (ce) begin
         sclk_reg <= sclk_lvl ^ clk_inv;
         sclk_oe_n_reg <= !master_mode;  // clock pin driven only as master
         // strobe active for exactly the master frame's data window
         sync_reg <= in_master ^ sync_pol;
         if (serial_mode) begin
            pin_out_reg  <= {ser_bit, 3'h0};
            pin_oe_n_reg <= 1'b1;
         end else begin
            pin_out_reg  <= par_bits;
            pin_oe_n_reg <= 1'b0;
         end
      end
   end

   // =========================================================
   // outputs, all from flip-flops except pready, tied high, and res_ready, decoded from the fifo count
   assign prdata                  = prdata_reg;
   assign pready                  = 1'b1;
   assign pslverr                 = pslverr_reg;
   assign busy                    = busy_reg;
   assign parallel_bit_seven_out  = pin_out_reg[0];
   assign parallel_bit_eight_out  = pin_out_reg[1];
   assign parallel_bit_nine_out   = pin_out_reg[2];
   assign parallel_bit_ten        = pin_out_reg[3];
   assign parallel_bit_seven_oe_n = pin_oe_n_reg;
   assign parallel_bit_eight_oe_n = pin_oe_n_reg;
   assign parallel_bit_nine_oe_n  = pin_oe_n_reg;
   assign sclk_out                = sclk_reg;
   assign sclk_oe_n               = sclk_oe_n_reg;
   assign frame_sync              = sync_reg;
endmodule // asr_port

//--- asr_pkg.sv
// asr_pkg: constants for the serial result port of the 18-bit converter.
// assumes 32-bit apb words, 125 mhz pclk, word-aligned register offsets.
package asr_pkg;

   // =========================================================
   // widths
   localparam int RES_W    = 18;  // conversion result width
   localparam int FIFO_D   = 16;  // result fifo depth
   localparam int CNT_W    = 5;   // bit counter width

   // =========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_DIV    = 8'h04;
   localparam logic [7:0] OFF_CONV   = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;

   // =========================================================
   // ctrl fields
   localparam int CTRL_MODE_LO = 0;  // mode, two bits
   localparam int CTRL_CSRC    = 2;  // clock_source_select, 1 = slave
   localparam int CTRL_CODE    = 3;  // coding_select, 1 = straight binary
   localparam logic [3:0] CTRL_RESET = 4'h3;  // serial, master, 2s comp

   // div fields: quarter bit period in pclk cycles
   localparam int DIV_RDC_LO  = 8;   // read-during-convert quarter period
   localparam logic [15:0] DIV_RESET = 16'h0402;

   // conv and status fields
   localparam int CONV_START  = 0;
   localparam int ST_BUSY     = 0;
   localparam int ST_FRAME    = 1;
   localparam int ST_LVL_LO   = 8;   // fifo level, five bits

   // =========================================================
   // interface modes
   localparam logic [1:0] MODE_SERIAL = 2'h3;

   // =========================================================
   // frame engine states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_MASTER = 2'b01,
      ST_SLAVE  = 2'b10
   } asr_state_t;

   // read-during-convert frames run with quarter bit periods of at least this time
   localparam int  RDC_MIN_NS   = 16;
   localparam int  CLK_NS       = 8;
   localparam logic [7:0] RDC_MIN_Q =
      8'((RDC_MIN_NS + CLK_NS - 1) / CLK_NS);

endpackage

//--- asr_port_chk.sv
// asr_port_chk: concurrent checks on the serial result port pins.
// assumes the register map of asr_pkg and 2-flop pin synchronisers.
`timescale 1ns/1ps
// =========================================================
// checker
module asr_port_chk (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   // result stream and pins
   input wire logic        res_valid,
   input wire logic        res_ready,
   input wire logic        busy,
   input wire logic        parallel_bit_seven_in,
   input wire logic        parallel_bit_eight_in,
   input wire logic        parallel_bit_nine_in,
   input wire logic        parallel_bit_seven_oe_n,
   input wire logic        parallel_bit_eight_oe_n,
   input wire logic        parallel_bit_nine_oe_n,
   input wire logic        parallel_bit_ten,
   input wire logic        sclk_out,
   input wire logic        sclk_oe_n,
   input wire logic        frame_sync
);
   // mirrors of ctrl, fifo count and the pin synchronisers
   logic [3:0] ctrl_q;
   logic [4:0] cnt;
   logic [2:0] p1, p2, p3;
   wire wr_en  = psel & penable & pwrite & ce;
   wire push   = res_valid & res_ready & ce;
   wire pop    = busy & (cnt != 5'h00) & ce;
   wire par    = ctrl_q[1:0] != 2'h3;
   wire master = ~par & ~ctrl_q[2];
   wire act    = frame_sync ^ p3[0];  // strobe at its active level

   // third stage so pins are settled before they are trusted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 4'h3;
         cnt <= 5'h00;
         {p1, p2, p3} <= 9'h000;
      end else begin
         if (wr_en && paddr == 8'h00) ctrl_q <= pwdata[3:0];
         cnt <= cnt + 5'(push) - 5'(pop);
         p1 <= {parallel_bit_nine_in, parallel_bit_eight_in,
                parallel_bit_seven_in};
         p2 <= p1;
         p3 <= p2;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence conv_wr;
      wr_en && paddr == 8'h08 && pwdata[0];
   endsequence
   sequence frame_go;
      master && $rose(act);
   endsequence

   a_busy_start: assert property (conv_wr ##0 !busy |=> busy)
      else $error("busy did not rise on conversion start");
   a_busy_latch: assert property (pop |=> !busy)
      else $error("busy stayed high after result latch");
   a_busy_hold: assert property (busy && cnt == 5'h00 |=> busy)
      else $error("busy fell with no result to latch");
   a_ready_full: assert property (res_ready == (cnt != 5'h10))
      else $error("result ready disagrees with fifo fill");
   a_parallel_drive: assert property (par ##1 par |->
      !(parallel_bit_seven_oe_n | parallel_bit_eight_oe_n |
        parallel_bit_nine_oe_n))
      else $error("shared pins not driven in parallel mode");
   a_sclk_dir: assert property (sclk_oe_n == !$past(master))
      else $error("serial clock direction wrong");
   a_sync_level: assert property (
      master && !p3[1] && $rose(sclk_out) |-> act)
      else $error("strobe not active during serial clock");
   a_data_steady: assert property (
      master && $changed(sclk_out) |-> $stable(parallel_bit_ten))
      else $error("serial data moved on a clock edge");
   a_rac_start: assert property (
      frame_go ##0 !p3[2] |-> !busy && !$past(busy))
      else $error("frame started before conversion end");
   a_rdc_start: assert property (frame_go ##0 p3[2] |-> busy)
      else $error("read during convert frame outside conversion");
   a_unmapped: assert property (
      psel && !penable && paddr > 8'h10 |=> pslverr)
      else $error("unmapped access not refused");
endmodule // asr_port_chk

bind asr_port asr_port_chk u_chk (.pclk, .presetn, .ce, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pslverr, .res_valid, .res_ready, .busy,
   .parallel_bit_seven_in, .parallel_bit_eight_in, .parallel_bit_nine_in,
   .parallel_bit_seven_oe_n, .parallel_bit_eight_oe_n,
   .parallel_bit_nine_oe_n, .parallel_bit_ten, .sclk_out, .sclk_oe_n,
   .frame_sync);

//--- asr_host.sv
// asr_host: host reading conversion results over the slave serial link.
// assumes the bench routes its clock onto the sclk pin and its chain bit onto a shared pin.
`timescale 1ns/1ps
// =========================================================
// host model
module asr_host (
   // link outputs
   output logic     sclk,
   output logic     cs_n,
   output logic     rd_n,
   output logic     chain,
   // serial data from the port
   input wire logic sdo
);
   // select high and clock parked between frames
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      rd_n = 1'h1;
      chain = 1'h0;
   end
   // 36 bits: the result, then the chained word behind it
   task automatic read_frame(input logic inv, input logic [17:0] cp,
                             output logic [35:0] w);
      sclk = inv;
      #62.5;
      cs_n = 1'h0;
      rd_n = 1'h0;
      for (int i = 0; i < 36; i++) begin
         #62.5;
         w = {w[34:0], sdo};  // sampled a full period after update, just before the next
         chain = (i < 18) ? cp[17 - i] : ~chain;
         sclk = ~inv;  // update edge flips with inversion
         #62.5;
         sclk = inv;
      end
      #62.5;
      cs_n = 1'h1;
      rd_n = 1'h1;
      chain = ~chain;  // released line must not keep a stale level
   endtask
endmodule // asr_host

//--- asr_port_test.sv
// asr_port_test: self-checking bench for the serial result port.
// assumes asr_port_chk is bound and asr_host plays the reading host.
`timescale 1ns/1ps
// =========================================================
// bench
module asr_port_test;
   import asr_pkg::*;
   logic        pclk = 0, presetn = 0;
   logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        res_valid = 0, res_ready, busy, er;
   logic [RES_W-1:0] res_data = 18'h00000, last_res = 18'h00000;
   logic        pol_r = 0, inv_r = 0, rdc_r = 0, slv_r = 0;
   logic        p7_o, p7_oe_n, p8_o, p8_oe_n, p9_o, p9_oe_n, p10;
   logic        sclk_out, sclk_oe_n, frame_sync, h_sclk, h_cs_n, h_rd_n;
   logic        h_chain;
   int          n_errors = 0, check_count = 0;
   // wire levels from every party's enable
   wire p7 = p7_oe_n ? pol_r : p7_o;
   wire p8 = p8_oe_n ? inv_r : p8_o;
   wire p9 = p9_oe_n ? (slv_r ? h_chain : rdc_r) : p9_o;
   wire sclk_w = sclk_oe_n ? h_sclk : sclk_out;

   always #4 pclk = ~pclk;

   asr_port DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .res_valid, .res_data,
      .res_ready, .busy, .parallel_bit_seven_in(p7),
      .parallel_bit_seven_out(p7_o), .parallel_bit_seven_oe_n(p7_oe_n),
      .parallel_bit_eight_in(p8), .parallel_bit_eight_out(p8_o),
      .parallel_bit_eight_oe_n(p8_oe_n), .parallel_bit_nine_in(p9),
      .parallel_bit_nine_out(p9_o), .parallel_bit_nine_oe_n(p9_oe_n),
      .parallel_bit_ten(p10), .sclk_in(sclk_w), .sclk_out, .sclk_oe_n,
      .cs_n(h_cs_n), .rd_n(h_rd_n), .frame_sync);
   asr_host host (.sclk(h_sclk), .cs_n(h_cs_n), .rd_n(h_rd_n),
      .chain(h_chain), .sdo(p10));

   task chk(input logic [35:0] seen, input logic [35:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one apb transfer, held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task push(input logic [17:0] v);
      @(posedge pclk);
      res_valid <= 1;
      res_data <= v;
      do @(posedge pclk); while (res_ready !== 1'b1);
      res_valid <= 0;
   endtask
   task start;
      apb(1, OFF_CONV, 32'h1);
      @(negedge pclk);
      chk(busy, 1);
   endtask
   task idle;
      for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge pclk);
      chk(busy, 0);
   endtask
   // selects move only while the pins are parallel outputs
   task mode(input logic [3:0] c, input logic pol, inv, read_during_convert_select, slv);
      apb(1, OFF_CTRL, 32'h0);
      pol_r <= pol; inv_r <= inv; rdc_r <= read_during_convert_select; slv_r <= slv;
      repeat (4) @(posedge pclk);
      apb(1, OFF_CTRL, {28'h0, c});
      repeat (200) @(posedge pclk);
   endtask

   task t_regs;
      apb(0, OFF_CTRL, 0); chk(rd, 32'h3);
      apb(0, OFF_DIV, 0); chk(rd, 32'h402);
      apb(0, 8'h40, 0); chk({er, rd}, 36'h100000000);
   endtask
   task t_par(input logic [17:0] v);
      apb(1, OFF_CTRL, 32'h0);
      push(v);
      start;
      idle;
      last_res = v;
      repeat (3) @(negedge pclk);
      chk({p10, p9_o, p8_o, p7_o, p9_oe_n, p8_oe_n, p7_oe_n},
          {v[10:7], 3'h0});
      apb(0, OFF_RESULT, 0); chk(rd, v);
   endtask
   task t_mst(input logic pol, inv, read_during_convert_select, code, input logic [17:0] v);
      logic [17:0] w, ex;
      logic        prev;
      int          n, cyc, last, per;
      mode({code, 3'h3}, pol, inv, read_during_convert_select, 0);
      ex = read_during_convert_select ? last_res : v;
      ex = code ? ex : ex ^ 18'h20000;
      if (!read_during_convert_select) push(v);
      start;
      n = 0; cyc = 0; last = 0; per = 0; prev = sclk_out;
      while (n < 18 && cyc < 2000) begin
         @(posedge pclk);
         cyc++;
         if (sclk_out === !inv && prev === inv) begin
            w = {w[16:0], p10};
            chk(frame_sync, !pol);
            per = cyc - last;
            last = cyc;
            n++;
         end
         prev = sclk_out;
      end
      chk(w, ex);
      chk(per, read_during_convert_select ? 16 : 8);
      if (read_during_convert_select) push(v);
      idle;
      last_res = v;
      repeat (40) @(negedge pclk);
      chk(frame_sync, pol);
   endtask
   task t_slv(input logic inv, input logic [17:0] cp);
      logic [35:0] w;
      mode(4'hF, 0, inv, 0, 1);
      host.read_frame(inv, cp, w);
      chk(w, {last_res, cp});
   endtask
   // fill the fifo until it refuses, then drain it by latching
   task t_fifo;
      apb(1, OFF_CTRL, 32'h0);
      for (int i = 0; i < 16; i++) push(18'h00100 + 18'(i));
      @(negedge pclk);
      chk(res_ready, 0);
      apb(0, OFF_STATUS, 0); chk(rd[12:8], 5'h10);
      for (int i = 0; i < 16; i++) begin
         start;
         idle;
      end
      apb(0, OFF_RESULT, 0); chk(rd, 32'h0010F);
      apb(0, OFF_STATUS, 0); chk(rd[12:8], 5'h00);
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_par(18'h2AD5B);
      t_mst(0, 0, 0, 1, 18'h2B3C5);
      t_mst(1, 0, 0, 0, 18'h1A5F0);
      t_mst(0, 1, 0, 1, 18'h3F00F);
      t_mst(0, 0, 1, 1, 18'h05A3C);
      t_slv(0, 18'h2C3A1);
      t_slv(1, 18'h15E96);
      t_fifo;
      end_sim;
   end
   // watchdog well past the expected run length
   initial begin
      #300000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim;
   end
endmodule // asr_port_test
